// File: rtl/transmitter_config_registers.v
// Purpose: six byte-wide configuration registers of a sub-GHz transmitter and the logic they steer
// Assumes: ref_clk is the crystal clock; reg_wr/reg_rd are single-cycle strobes from the serial control port
// Notes: divided crystal clock and baud clocks run as enable pulses on ref_clk; clock output toggles on the divided clock pulse
// Function
// - leaving full-off, hold clock output idle for the programmed delay before toggling
// - delay codes 0..3 give 64, 128, 256, 512 divided clock cycles
// - baud post-divider codes 1..5 divide by 1..5; 0, 6, 7 reserved
// - baud pre-divider divides by 3..255; 0..2 reserved; resets to 3
// - low-power code 0 shuts oscillator, synthesiser and amplifier
// - low-power code 1 keeps oscillator, shuts synthesiser and amplifier
// - low-power code 2 keeps oscillator and synthesiser, shuts amplifier
// - low-power code 3 acts as code 2
// - six-bit Gaussian shaping step for the modulator, reset zero
// - boost bit selects boosted amplifier output, meant above 850MHz
// - amplifier power code N enables N+1 parallel drivers
// - digital clock is crystal clock divided by 4, 5, 6 or 7
`timescale 1ns/1ps
`include "tx_cfg_consts.vh"
module transmitter_config_registers (
  input wire ref_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [1:0] digital_clock_divider,
  input wire low_power_request,
  output reg crystal_oscillator_enable,
  output reg synth_enable,
  output reg amplifier_enable,
  output reg buffered_clock_output,
  output reg baud_tick,
  output reg [5:0] gaussian_shaping_step,
  output reg high_band_power_boost,
  output reg [7:0] amplifier_driver_enable
);
  reg [7:0] clk_out_baud_post;
  reg [7:0] baud_pre_divider;
  reg [7:0] low_power_select;
  reg [7:0] shaping_step;
  reg [7:0] amp_boost_control;
  reg [7:0] amp_power_control;
  reg lp_req_meta;
  reg lp_req_sync;
  reg [1:0] power_state;
  reg [1:0] next_power_state;
  reg [2:0] dig_count;
  reg dig_tick;
  reg [9:0] delay_count;
  reg clk_out_run;
  reg [2:0] next_dig_count;
  wire pre_tick;
  wire post_tick;
  wire [1:0] low_power_state_select;
  wire [1:0] clock_output_start_delay;
  wire [2:0] baud_clock_post_divider;
  wire [9:0] start_delay_cycles;

  // power states; only full-off stops the oscillator
  localparam ST_ACTIVE = 2'b00;
  localparam ST_FULL_OFF = 2'b01;
  localparam ST_STANDBY = 2'b10;
  localparam ST_FAST_WAKE = 2'b11;

  function [1:0] effective_mode;
    input [1:0] code;
    begin
      effective_mode = (code == `LP_REVERT) ? `LP_FAST_WAKE : code;
    end
  endfunction

  function [7:0] masked;
    input [7:0] value;
    input [7:0] mask;
    begin
      masked = value & mask;
    end
  endfunction

  // code 3 folds into the fast-wake state
  function [1:0] entry_state;
    input [1:0] code;
    begin
      case (effective_mode(code))
        `LP_SHUTDOWN: entry_state = ST_FULL_OFF;
        `LP_STANDBY: entry_state = ST_STANDBY;
        default: entry_state = ST_FAST_WAKE;
      endcase
    end
  endfunction

  function [7:0] read_value;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_CLK_OUT_BAUD_POST: read_value = clk_out_baud_post;
        `ADDR_BAUD_PRE_DIVIDER: read_value = baud_pre_divider;
        `ADDR_LOW_POWER_SELECT: read_value = low_power_select;
        `ADDR_SHAPING_STEP: read_value = shaping_step;
        `ADDR_AMP_BOOST_CONTROL: read_value = amp_boost_control;
        `ADDR_AMP_POWER_CONTROL: read_value = amp_power_control;
        default: read_value = 8'h00;
      endcase
    end
  endfunction

  assign low_power_state_select = low_power_select[1:0];
  assign clock_output_start_delay = clk_out_baud_post[`START_DELAY_MSB:`START_DELAY_LSB];
  assign baud_clock_post_divider = clk_out_baud_post[`POST_DIV_MSB:`POST_DIV_LSB];
  assign start_delay_cycles = `START_DELAY_BASE << clock_output_start_delay;

  // register writes; reserved bits are masked to zero on write, except in the pre-divider, which keeps all eight bits
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_out_baud_post <= `RST_CLK_OUT_BAUD_POST;
      baud_pre_divider <= `RST_BAUD_PRE_DIVIDER;
      low_power_select <= `RST_LOW_POWER_SELECT;
      shaping_step <= `RST_SHAPING_STEP;
      amp_boost_control <= `RST_AMP_BOOST_CONTROL;
      amp_power_control <= `RST_AMP_POWER_CONTROL;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_CLK_OUT_BAUD_POST: begin
          clk_out_baud_post <= masked(reg_wdata, `MASK_CLK_OUT_BAUD_POST);
        end
        `ADDR_BAUD_PRE_DIVIDER: begin
          baud_pre_divider <= reg_wdata;
        end
        `ADDR_LOW_POWER_SELECT: begin
          low_power_select <= masked(reg_wdata, `MASK_LOW_POWER_SELECT);
        end
        `ADDR_SHAPING_STEP: begin
          shaping_step <= masked(reg_wdata, `MASK_SHAPING_STEP);
        end
        `ADDR_AMP_BOOST_CONTROL: begin
          amp_boost_control <= masked(reg_wdata, `MASK_AMP_BOOST_CONTROL);
        end
        `ADDR_AMP_POWER_CONTROL: begin
          amp_power_control <= masked(reg_wdata, `MASK_AMP_POWER_CONTROL);
        end
        default: begin
          amp_power_control <= amp_power_control;
        end
      endcase
    end
  end

  // read data registered; unmapped offsets answer zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_value(reg_addr);
    end
  end

  // low-power request comes from a pin, so it is synchronised first
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lp_req_meta <= 1'b0;
      lp_req_sync <= 1'b0;
    end else begin
      lp_req_meta <= low_power_request;
      lp_req_sync <= lp_req_meta;
    end
  end

  // mode is latched on entry so a rewrite during low power does not change what is off
  always @* begin
    next_power_state = power_state;
    case (power_state)
      ST_ACTIVE: begin
        if (lp_req_sync) begin
          next_power_state = entry_state(low_power_state_select);
        end
      end
      ST_FULL_OFF, ST_STANDBY, ST_FAST_WAKE: begin
        if (!lp_req_sync) begin
          next_power_state = ST_ACTIVE;
        end
      end
      default: begin
        next_power_state = ST_ACTIVE;
      end
    endcase
  end

  // enables decode the next state so they move on the same edge as the state
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      power_state <= ST_ACTIVE;
      crystal_oscillator_enable <= 1'b1;
      synth_enable <= 1'b1;
      amplifier_enable <= 1'b1;
    end else begin
      power_state <= next_power_state;
      case (next_power_state)
        ST_FULL_OFF: begin
          crystal_oscillator_enable <= 1'b0;
          synth_enable <= 1'b0;
          amplifier_enable <= 1'b0;
        end
        ST_STANDBY: begin
          crystal_oscillator_enable <= 1'b1;
          synth_enable <= 1'b0;
          amplifier_enable <= 1'b0;
        end
        ST_FAST_WAKE: begin
          crystal_oscillator_enable <= 1'b1;
          synth_enable <= 1'b1;
          amplifier_enable <= 1'b0;
        end
        default: begin
          crystal_oscillator_enable <= 1'b1;
          synth_enable <= 1'b1;
          amplifier_enable <= 1'b1;
        end
      endcase
    end
  end

  // divided crystal clock enable; divide ratio 4..7
  always @* begin
    next_dig_count = dig_count + 3'h1;
    if (next_dig_count >= (`DIGDIV_BASE + {1'b0, digital_clock_divider})) begin
      next_dig_count = 3'h0;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dig_count <= 3'h0;
      dig_tick <= 1'b0;
    end else if (!crystal_oscillator_enable) begin
      dig_count <= 3'h0;
      dig_tick <= 1'b0;
    end else begin
      dig_count <= next_dig_count;
      dig_tick <= (next_dig_count == 3'h0);
    end
  end

  // clock output start delay: restart count on every exit from full-off
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      delay_count <= 10'h000;
      clk_out_run <= 1'b0;
      buffered_clock_output <= 1'b0;
    end else if (!crystal_oscillator_enable) begin
      delay_count <= 10'h000;
      clk_out_run <= 1'b0;
      buffered_clock_output <= 1'b0;
    end else if (dig_tick) begin
      if (!clk_out_run) begin
        if (delay_count + 10'h001 >= start_delay_cycles) begin
          clk_out_run <= 1'b1;
        end else begin
          delay_count <= delay_count + 10'h001;
        end
      end else begin
        buffered_clock_output <= ~buffered_clock_output;
      end
    end
  end

  // baud clock: pre-divider then post-divider, both as enable chains
  clock_enable_divider #(.WIDTH(8)) u_pre_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .run(synth_enable),
    .div(baud_pre_divider),
    .tick_in(dig_tick),
    .tick_out(pre_tick)
  );

  clock_enable_divider #(.WIDTH(3)) u_post_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .run(synth_enable),
    .div(baud_clock_post_divider),
    .tick_in(pre_tick),
    .tick_out(post_tick)
  );

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      baud_tick <= 1'b0;
      gaussian_shaping_step <= 6'h00;
      high_band_power_boost <= 1'b0;
      amplifier_driver_enable <= 8'h01;
    end else begin
      baud_tick <= post_tick;
      gaussian_shaping_step <= shaping_step[5:0];
      high_band_power_boost <= amp_boost_control[`BOOST_BIT];
      // thermometer code: code N lights drivers 0..N
      amplifier_driver_enable <= 8'hFF >> (3'h7 - amp_power_control[`DRIVER_MSB:0]);
    end
  end
endmodule // transmitter_config_registers

// File: rtl/tx_cfg_consts.vh
// Purpose: offsets, field positions, reset values and timing counts for the transmitter config slice
// Assumes: byte-wide registers reached by index on the serial control port
// Notes: definitions only
`ifndef TX_CFG_CONSTS_VH
`define TX_CFG_CONSTS_VH
`define ADDR_CLK_OUT_BAUD_POST 8'h01
`define ADDR_BAUD_PRE_DIVIDER 8'h02
`define ADDR_LOW_POWER_SELECT 8'h03
`define ADDR_SHAPING_STEP 8'h04
`define ADDR_AMP_BOOST_CONTROL 8'h05
`define ADDR_AMP_POWER_CONTROL 8'h06
`define RST_CLK_OUT_BAUD_POST 8'h81
`define RST_BAUD_PRE_DIVIDER 8'h03
`define RST_LOW_POWER_SELECT 8'h00
`define RST_SHAPING_STEP 8'h00
`define RST_AMP_BOOST_CONTROL 8'h04
`define RST_AMP_POWER_CONTROL 8'h80
`define MASK_CLK_OUT_BAUD_POST 8'hC7
`define MASK_LOW_POWER_SELECT 8'h03
`define MASK_SHAPING_STEP 8'h3F
`define MASK_AMP_BOOST_CONTROL 8'h07
`define MASK_AMP_POWER_CONTROL 8'hE7
`define START_DELAY_MSB 7
`define START_DELAY_LSB 6
`define POST_DIV_MSB 2
`define POST_DIV_LSB 0
`define BOOST_BIT 0
`define DRIVER_MSB 2
`define START_DELAY_BASE 10'h040
`define LP_SHUTDOWN 2'h0
`define LP_STANDBY 2'h1
`define LP_FAST_WAKE 2'h2
`define LP_REVERT 2'h3
`define DIGDIV_BASE 3'h4
`endif

// File: rtl/clock_enable_divider.v
// Purpose: programmable divide-by-N enable pulse generator
// Assumes: divide value of zero is treated as one
// Notes: one-cycle enable every div tick_in pulses
`timescale 1ns/1ps
module clock_enable_divider #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire run,
  input wire [WIDTH-1:0] div,
  input wire tick_in,
  output reg tick_out
);
  reg [WIDTH-1:0] count;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else if (!run) begin
      count <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else if (tick_in) begin
      if (count + 1'b1 >= div) begin
        count <= {WIDTH{1'b0}};
        tick_out <= 1'b1;
      end else begin
        count <= count + 1'b1;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule // clock_enable_divider

// File: bench/tx_cfg_checker_properties.sv
// Purpose: port-level properties of the transmitter config slice
// Assumes: one ref_clk domain, resetn active low
// Notes: low-power mode is tracked from writes to offset 0x03
`timescale 1ns/1ps
module tx_cfg_checker (
  input wire ref_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire low_power_request,
  input wire crystal_oscillator_enable,
  input wire synth_enable,
  input wire amplifier_enable,
  input wire baud_tick,
  input wire [5:0] gaussian_shaping_step,
  input wire high_band_power_boost,
  input wire [7:0] amplifier_driver_enable
);
  reg [1:0] mode;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) mode <= 2'h0;
    else if (reg_wr && reg_addr == 8'h03) mode <= reg_wdata[1:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_step;
    logic [5:0] v;
    (reg_wr && reg_addr == 8'h04, v = reg_wdata[5:0]) |-> ##2 gaussian_shaping_step == v;
  endproperty
  property p_boost;
    logic v;
    (reg_wr && reg_addr == 8'h05, v = reg_wdata[0]) |-> ##2 high_band_power_boost == v;
  endproperty
  a_lp_entry_state: assert property ($rose(low_power_request) |-> ##4 (!amplifier_enable &&
    crystal_oscillator_enable == (mode != 2'h0) && synth_enable == mode[1])) else $error("bad low power state");
  a_lp_exit_on: assert property ($fell(low_power_request) |-> ##4
    (crystal_oscillator_enable && synth_enable && amplifier_enable)) else $error("bad exit state");
  a_driver_thermo: assert property (amplifier_driver_enable[0] &&
    ((amplifier_driver_enable & (amplifier_driver_enable + 8'h01)) == 8'h00)) else $error("bad driver set");
  a_step_follows: assert property (p_step) else $error("step not updated");
  a_boost_follows: assert property (p_boost) else $error("boost not updated");
  a_unmapped_zero: assert property (reg_rd && (reg_addr == 8'h00 || reg_addr > 8'h06) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_baud_single: assert property (baud_tick |=> !baud_tick) else $error("baud tick too long");
  a_baud_gated: assert property (!synth_enable ##1 !synth_enable ##1 !synth_enable |->
    !baud_tick) else $error("baud without synth");
  c_lp_entry: cover property ($rose(low_power_request));
  c_baud: cover property (baud_tick);
  c_unmapped: cover property (reg_rd && reg_addr == 8'h07);
endmodule // tx_cfg_checker
bind transmitter_config_registers tx_cfg_checker i_chk (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .low_power_request(low_power_request), .crystal_oscillator_enable(crystal_oscillator_enable),
  .synth_enable(synth_enable), .amplifier_enable(amplifier_enable), .baud_tick(baud_tick),
  .gaussian_shaping_step(gaussian_shaping_step), .high_band_power_boost(high_band_power_boost),
  .amplifier_driver_enable(amplifier_driver_enable));

// File: bench/tb_top.sv
// Purpose: self-checking bench for the transmitter config slice
// Assumes: inputs change on the falling edge of ref_clk
// Notes: toggle timing is checked with a small window for sync and tick phase
`timescale 1ns/1ps
module tb_top;
  reg ref_clk, resetn, reg_wr, reg_rd, low_power_request;
  reg [7:0] reg_addr, reg_wdata;
  reg [1:0] digital_clock_divider;
  wire [7:0] reg_rdata, amplifier_driver_enable;
  wire [5:0] gaussian_shaping_step;
  wire crystal_oscillator_enable, synth_enable, amplifier_enable, buffered_clock_output, baud_tick;
  wire high_band_power_boost;
  integer num_errors = 0, check_count = 0, i, n, c, e;
  transmitter_config_registers i_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .digital_clock_divider(digital_clock_divider), .low_power_request(low_power_request),
    .crystal_oscillator_enable(crystal_oscillator_enable), .synth_enable(synth_enable),
    .amplifier_enable(amplifier_enable), .buffered_clock_output(buffered_clock_output), .baud_tick(baud_tick),
    .gaussian_shaping_step(gaussian_shaping_step), .high_band_power_boost(high_band_power_boost),
    .amplifier_driver_enable(amplifier_driver_enable));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // extra cycle at the end lets registered copies settle before a check
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, exp);
    end
  endtask
  task tgl(output integer cnt);
    reg b;
    begin
      b = buffered_clock_output;
      cnt = 0;
      while (buffered_clock_output === b && cnt < 5000) begin
        @(negedge ref_clk);
        cnt = cnt + 1;
      end
    end
  endtask
  task tickw(output integer cnt);
    begin
      cnt = 1;
      @(negedge ref_clk);
      while (baud_tick !== 1'b1 && cnt < 2000) begin
        @(negedge ref_clk);
        cnt = cnt + 1;
      end
    end
  endtask
  task t_reset;
    begin
      for (i = 0; i < 8; i = i + 1) rd(i[7:0], (56'h80_04_00_00_03_81_00 >> (8 * i)) & 8'hFF);
      chk({gaussian_shaping_step, high_band_power_boost}, 7'h00);
      chk(amplifier_driver_enable, 8'h01);
      $display("test reset values done");
    end
  endtask
  task t_fields;
    begin
      for (i = 1; i < 7; i = i + 1) begin
        wr(i[7:0], 48'h87_FD_FF_FF_FF_C5 >> (8 * (i - 1)));
        rd(i[7:0], (48'h87_05_3F_03_FF_C5 >> (8 * (i - 1))) & 8'hFF);
      end
      chk({gaussian_shaping_step, high_band_power_boost}, 7'h7F);
      for (n = 0; n < 8; n = n + 1) begin
        wr(8'h06, 8'h80 | n[7:0]);
        chk(amplifier_driver_enable, (16'h0001 << (n + 1)) - 16'h0001);
      end
      wr(8'h05, 8'h04);
      chk({7'h00, high_band_power_boost}, 8'h00);
      $display("test field readback done");
    end
  endtask
  task t_low_power;
    begin
      for (n = 0; n < 4; n = n + 1) begin
        wr(8'h03, n[7:0]);
        low_power_request = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk({crystal_oscillator_enable, synth_enable, amplifier_enable}, n == 0 ? 0 : n == 1 ? 4 : 6);
        low_power_request = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({crystal_oscillator_enable, synth_enable, amplifier_enable}, 3'h7);
      end
      $display("test low power modes done");
    end
  endtask
  task t_clock_start;
    begin
      for (n = 0; n < 4; n = n + 1) begin
        wr(8'h01, {n[1:0], 6'h01});
        digital_clock_divider = n[1:0];
        wr(8'h03, 8'h00);
        low_power_request = 1'b1;
        repeat (8) @(negedge ref_clk);
        low_power_request = 1'b0;
        tgl(c);
        e = (64 << n) * (4 + n);
        chk(c >= e - (4 + n) && c <= e + 2 * (4 + n) + 6, 1'b1);
        tgl(c);
        chk(c, 4 + n);
      end
      $display("test clock start delay done");
    end
  endtask
  task t_baud(input [1:0] d, input [7:0] pre, input [2:0] post);
    begin
      digital_clock_divider = d;
      wr(8'h01, {5'h00, post});
      wr(8'h02, pre);
      tickw(c);
      tickw(c);
      tickw(c);
      chk(c, (4 + d) * pre * post);
      $display("test baud divide done");
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #1500000;
    num_errors = num_errors + 1;
    give_verdict;
  end
  initial begin
    resetn = 1'b0;
    {reg_wr, reg_rd, low_power_request} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    digital_clock_divider = 2'h0;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    t_reset;
    t_fields;
    t_low_power;
    t_clock_start;
    t_baud(2'h0, 8'h03, 3'h2);
    t_baud(2'h3, 8'h05, 3'h5);
    t_baud(2'h1, 8'hFF, 3'h1);
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    t_reset;
    give_verdict;
  end
endmodule // tb_top
